// [asi_params.svh]
// Register offsets, field positions, reset values and timing counts for the interlock
`ifndef ASI_PARAMS_SVH
`define ASI_PARAMS_SVH
`define ASI_ADDR_CTRL 4'h0
`define ASI_ADDR_FAULT 4'h1
`define ASI_ADDR_ACK 4'h2
`define ASI_ADDR_STATE 4'h3
`define ASI_ADDR_HEAT 4'h4
`define ASI_ADDR_RETRY 4'h5
`define ASI_ADDR_ID 4'h6
// Control register bits
`define ASI_CTRL_ESTOP_SET 0
`define ASI_CTRL_ESTOP_CLR 1
`define ASI_CTRL_FR_SET 2
`define ASI_CTRL_FR_CLR 3
`define ASI_CTRL_KEEPALIVE 4
`define ASI_CTRL_STOW_DONE 5
`define ASI_CTRL_ENC_RST 6
// Fault bit positions
`define ASI_F_ESTOP 0
`define ASI_F_FR 1
`define ASI_F_OTEMP 2
`define ASI_F_OCUR 3
`define ASI_F_BRK 4
`define ASI_F_ENC 5
`define ASI_F_OSPD 6
`define ASI_F_LIM1 7
`define ASI_F_LIM2 8
`define ASI_F_WIND 9
`define ASI_F_COMM 10
`define ASI_F_STUCK 11
`define ASI_NFAULT 12
// Thresholds as printed
`define ASI_OCUR_AMPS 31
`define ASI_OSPD_RPM 1500
`define ASI_WIND_MPH 50
`define ASI_COMM_LOSS_S 60
`define ASI_CLK_HZ 50000000
// Sixty seconds of system clock; too large for a signed int
`define ASI_COMM_CYCLES 32'hB2D05E00
// Head start given to a stow before a multi-breaker trip drops the drives
`define ASI_STOW_WAIT_CYCLES 8'h80
`define ASI_ENC_RST_US 10
`define ASI_ENC_RST_CYCLES (`ASI_ENC_RST_US * (`ASI_CLK_HZ / 1000000))
`define ASI_RETRY_RESET 8'h04
`define ASI_HEAT_RESET 8'h00
// Arbitrary value
`define ASI_DEVICE_ID 32'h00A5C0DE
`endif

// [asi_pkg.sv]
// Types shared by the antenna interlock
package asi_pkg;
   typedef enum logic [1:0] {ST_IDLE, ST_BACKOUT, ST_ENCRST} asi_lim_state_t;
endpackage

// [asi_interlock.sv]
// Antenna safety interlock and fault-response supervisor
// Notes on behaviour
// - Primary stop disables both axes, cuts thyristor drives, sets brakes.
// - Remote may set primary stop; remote clear ignored while local switch set it.
// - Separate focus/rotation stop removes focus/rotation drive power.
// - Focus/rotation stop also asserts the primary stop.
// - Primary stop never asserts the focus/rotation stop.
// - Remote may set focus/rotation stop like the primary stop.
// - One motor hot cuts that drive and field; both hot stows and cuts servo. No field output here: only the drive is cut.
// - Motor current above over-current threshold reports a fault.
// - One breaker cuts that drive; both or other breaker stows then cuts drive.
// - Encoder failure resets receiver board; persisting with vertical working stows.
// - Over-speed stows antenna and cuts drive.
// - First limit backs axis out, then resets receiver board and re-points.
// - Second limit removes axis drive power directly in hardware.
// - High wind stows and sets brakes until wind drops below threshold.
// - Manual mode ignores operations, no auto-stow, no automatic back-out.
// - Communication lost over about a minute stows the antenna.
// - Apex too cold switches on the heater tape.
// - Stuck apex limits repeated positioning attempts.
// - Stow, limits and shutdowns work without any processor.
`timescale 1ns/1ps
`include "asi_params.svh"
module asi_interlock #(
   parameter logic [31:0] COMM_CYCLES = `ASI_COMM_CYCLES,
   parameter int ENC_RST_CYCLES = `ASI_ENC_RST_CYCLES,
   parameter logic [31:0] DEVICE_ID = `ASI_DEVICE_ID // Arbitrary value
) (
   // Clock and reset
   input wire logic SYS_CLK,
   input wire logic RST,
   // Register port
   input wire logic [3:0] ADDR,
   input wire logic [31:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [31:0] RDATA,
   // Stop switches and mode (pins)
   input wire logic ESTOP_LOCAL,
   input wire logic FR_ESTOP_LOCAL,
   input wire logic MANUAL_MODE,
   // Horizontal and vertical axis sensors, bit0 motor 1, bit1 motor 2
   input wire logic [1:0] HZ_OTEMP,
   input wire logic [1:0] VT_OTEMP,
   input wire logic [1:0] HZ_BRK_OPEN,
   input wire logic [1:0] VT_BRK_OPEN,
   input wire logic OTHER_BRK_OPEN,
   input wire logic HZ_OCUR,
   input wire logic VT_OCUR,
   input wire logic HZ_OSPD,
   input wire logic VT_OSPD,
   input wire logic ENC_FAIL,
   input wire logic VT_OK,
   // Limit switches, bit0 horizontal_axis, bit1 vertical_axis
   input wire logic [1:0] LIMIT1,
   input wire logic [1:0] LIMIT2,
   // Environment
   input wire logic WIND_HIGH,
   input wire logic APEX_COLD,
   input wire logic APEX_MOVE_FAIL,
   // Outputs to drives
   output logic HZ_AXIS_ENABLE,
   output logic VT_AXIS_ENABLE,
   output logic [1:0] HZ_DRIVE_ON,
   output logic [1:0] VT_DRIVE_ON,
   output logic THYRISTOR_POWER,
   output logic BRAKE_SET,
   output logic STOW_REQ,
   output logic [1:0] BACKOUT_REQ,
   output logic ENC_BOARD_RESET,
   output logic REPOINT_REQ,
   output logic FR_POWER,
   output logic TRANSLATOR_ENABLE,
   output logic HEATER_ON,
   output logic FAULT_ANY
);

   // Two-flop synchronisers for every pin input
   // Reset to the inactive level, so leaving reset never looks like a stop or a fault
   localparam int NIN = 25;
   logic [NIN-1:0] pin_raw;
   logic [NIN-1:0] sync1_r;
   logic [NIN-1:0] sync2_r;
   assign pin_raw = {ESTOP_LOCAL, FR_ESTOP_LOCAL, MANUAL_MODE, HZ_OTEMP, VT_OTEMP,
                     HZ_BRK_OPEN, VT_BRK_OPEN, OTHER_BRK_OPEN, HZ_OCUR, VT_OCUR,
                     HZ_OSPD, VT_OSPD, ENC_FAIL, VT_OK, LIMIT1, LIMIT2, WIND_HIGH,
                     APEX_COLD, APEX_MOVE_FAIL};
   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         sync1_r <= '0;
         sync2_r <= '0;
      end else begin
         sync1_r <= pin_raw;
         sync2_r <= sync1_r;
      end
   end

   logic estop_loc, fr_loc, manual, oth_brk, hz_oc, vt_oc, hz_os, vt_os;
   logic enc_fail, vt_ok, wind, cold, move_fail;
   logic [1:0] hz_ot, vt_ot, hz_brk, vt_brk, lim1, lim2;
   assign {estop_loc, fr_loc, manual, hz_ot, vt_ot, hz_brk, vt_brk, oth_brk, hz_oc,
           vt_oc, hz_os, vt_os, enc_fail, vt_ok, lim1, lim2, wind, cold,
           move_fail} = sync2_r;

   // Register write decode; operations commands ignored in manual mode
   // Keepalive and housekeeping bits stay live so a local session keeps contact
   logic wr_ctrl, ops_ok;
   assign wr_ctrl = WR && (ADDR == `ASI_ADDR_CTRL);
   assign ops_ok = wr_ctrl && !manual;
   function automatic logic cbit(input logic [31:0] d, input int pos);
      return d[pos];
   endfunction

   // Primary stop: remote latch clearable only when no local switch holds it
   logic remote_stop_r, fr_remote_r, estop_local_r;
   logic fr_stop, estop;
   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         remote_stop_r <= 1'b0;
         estop_local_r <= 1'b0;
      end else begin
         if (estop_loc) begin
            estop_local_r <= 1'b1;
         end else if (ops_ok && cbit(WDATA, `ASI_CTRL_ESTOP_CLR) && !estop_loc) begin
            estop_local_r <= 1'b0;
         end
         if (ops_ok && cbit(WDATA, `ASI_CTRL_ESTOP_SET)) begin
            remote_stop_r <= 1'b1;
         end else if (ops_ok && cbit(WDATA, `ASI_CTRL_ESTOP_CLR) && !estop_loc) begin
            remote_stop_r <= 1'b0;
         end
      end
   end

   // Focus/rotation stop; never fed from the primary stop
   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         fr_remote_r <= 1'b0;
      end else if (ops_ok && cbit(WDATA, `ASI_CTRL_FR_SET)) begin
         fr_remote_r <= 1'b1;
      end else if (ops_ok && cbit(WDATA, `ASI_CTRL_FR_CLR)) begin
         fr_remote_r <= 1'b0;
      end
   end
   assign fr_stop = fr_loc || fr_remote_r;
   // Local primary stop must be released locally: a switch still held keeps it
   assign estop = estop_loc || estop_local_r || remote_stop_r || fr_stop;

   // Communication watchdog; software writes the keepalive bit
   // Counter saturates, so a long silence cannot wrap round and clear the loss
   logic [31:0] comm_cnt_r;
   logic comm_lost;
   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         comm_cnt_r <= '0;
      end else if (wr_ctrl && cbit(WDATA, `ASI_CTRL_KEEPALIVE)) begin
         comm_cnt_r <= '0;
      end else if (comm_cnt_r < 32'(COMM_CYCLES)) begin
         comm_cnt_r <= comm_cnt_r + 32'h1;
      end
   end
   assign comm_lost = (comm_cnt_r >= 32'(COMM_CYCLES));

   // Encoder board reset pulse and persistence check
   // One reset per failure episode; another try waits until the failure clears
   logic [15:0] enc_cnt_r;
   logic enc_tried_r, enc_persist;
   logic lim_enc_rst;
   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         enc_cnt_r <= '0;
         enc_tried_r <= 1'b0;
      end else if (enc_cnt_r != 16'h0) begin
         enc_cnt_r <= enc_cnt_r - 16'h1;
      end else if ((enc_fail && !enc_tried_r) || lim_enc_rst ||
                   (wr_ctrl && cbit(WDATA, `ASI_CTRL_ENC_RST))) begin
         enc_cnt_r <= 16'(ENC_RST_CYCLES);
         enc_tried_r <= enc_fail || enc_tried_r;
      end else if (!enc_fail) begin
         enc_tried_r <= 1'b0;
      end
   end
   assign ENC_BOARD_RESET = (enc_cnt_r != 16'h0);
   assign enc_persist = enc_fail && enc_tried_r && (enc_cnt_r == 16'h0);

   // First-limit back-out sequence, one per axis
   // Manual mode drops the sequence to idle and leaves the axis to the operator
   asi_pkg::asi_lim_state_t lim_st_r [2];
   logic [1:0] backout, repoint;
   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_lim
         always_ff @(posedge SYS_CLK) begin
            if (RST) begin
               lim_st_r[g] <= asi_pkg::ST_IDLE;
            end else begin
               case (lim_st_r[g])
                  asi_pkg::ST_IDLE: begin
                     if (lim1[g] && !manual) begin
                        lim_st_r[g] <= asi_pkg::ST_BACKOUT;
                     end
                  end
                  asi_pkg::ST_BACKOUT: begin
                     if (manual) begin
                        lim_st_r[g] <= asi_pkg::ST_IDLE;
                     end else if (!lim1[g]) begin
                        lim_st_r[g] <= asi_pkg::ST_ENCRST;
                     end
                  end
                  asi_pkg::ST_ENCRST: lim_st_r[g] <= asi_pkg::ST_IDLE;
                  default: lim_st_r[g] <= asi_pkg::ST_IDLE;
               endcase
            end
         end
         assign backout[g] = (lim_st_r[g] == asi_pkg::ST_BACKOUT);
         assign repoint[g] = (lim_st_r[g] == asi_pkg::ST_ENCRST);
      end
   endgenerate
   assign lim_enc_rst = |repoint;

   // Apex retry limiter: counts failed positioning attempts
   logic [7:0] retry_max_r, retry_cnt_r, heat_cfg_r;
   logic stuck;
   logic move_fail_d_r;
   // One attempt per rising edge of the failure flag, however long the report lasts
   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         move_fail_d_r <= 1'b0;
      end else begin
         move_fail_d_r <= move_fail;
      end
   end
   // Count holds at the limit until software reports the stow done
   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         retry_cnt_r <= '0;
      end else if (wr_ctrl && cbit(WDATA, `ASI_CTRL_STOW_DONE)) begin
         retry_cnt_r <= '0;
      end else if (move_fail && !move_fail_d_r && !stuck) begin
         retry_cnt_r <= retry_cnt_r + 8'h1;
      end
   end
   assign stuck = (retry_cnt_r >= retry_max_r);

   // Configuration registers
   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         retry_max_r <= `ASI_RETRY_RESET;
         heat_cfg_r <= `ASI_HEAT_RESET;
      end else if (WR && ADDR == `ASI_ADDR_RETRY) begin
         retry_max_r <= WDATA[7:0];
      end else if (WR && ADDR == `ASI_ADDR_HEAT) begin
         heat_cfg_r <= WDATA[7:0];
      end
   end

   // Fault conditions and responses, all pure hardware
   logic hz_both_hot, vt_both_hot, brk_multi, overspeed, auto_stow;
   assign hz_both_hot = &hz_ot;
   assign vt_both_hot = &vt_ot;
   assign brk_multi = (&hz_brk) || (&vt_brk) || oth_brk;
   assign overspeed = hz_os || vt_os;
   assign auto_stow = !manual && (hz_both_hot || vt_both_hot || brk_multi ||
                      overspeed || wind || comm_lost || (enc_persist && vt_ok));
   logic servo_cut;
   assign servo_cut = hz_both_hot || vt_both_hot || overspeed;
   assign STOW_REQ = auto_stow;

   // Drive enables per motor; stow for breakers attempted before drive drop
   logic brk_cut;
   logic [7:0] brk_wait_r;
   // Stow gets a fixed head start: cutting the drives first would strand the dish
   // Limitation: the head start is a cycle count, not a confirmed stow position
   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         brk_wait_r <= 8'h00;
      end else if (!brk_multi) begin
         brk_wait_r <= 8'h00;
      end else if (brk_wait_r != `ASI_STOW_WAIT_CYCLES) begin
         brk_wait_r <= brk_wait_r + 8'h01;
      end
   end
   // In manual mode nobody stows for us, so the drives drop at once
   assign brk_cut = brk_multi && (manual || (brk_wait_r == `ASI_STOW_WAIT_CYCLES));
   assign HZ_DRIVE_ON = ~hz_ot & ~hz_brk &
                        {2{!estop && !servo_cut && !lim2[0] && !brk_cut}};
   assign VT_DRIVE_ON = ~vt_ot & ~vt_brk &
                        {2{!estop && !servo_cut && !lim2[1] && !brk_cut}};
   assign HZ_AXIS_ENABLE = !estop && !lim2[0];
   assign VT_AXIS_ENABLE = !estop && !lim2[1];
   assign THYRISTOR_POWER = !estop;
   assign BRAKE_SET = estop || (wind && !manual);
   assign BACKOUT_REQ = backout;
   assign REPOINT_REQ = |repoint;
   assign FR_POWER = !fr_stop;
   assign TRANSLATOR_ENABLE = !fr_stop && !stuck;
   assign HEATER_ON = cold || heat_cfg_r[0];

   // Sticky faults: a new event wins over an acknowledge in the same cycle
   // Faults outlive their cause so a brief trip is still seen by software
   logic [`ASI_NFAULT-1:0] fault_now, fault_r;
   assign fault_now = {stuck, comm_lost, wind, |lim2, |lim1, overspeed, enc_fail,
                       brk_multi || (|hz_brk) || (|vt_brk), hz_oc || vt_oc,
                       (|hz_ot) || (|vt_ot), fr_stop, estop};
   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         fault_r <= '0;
      end else if (WR && ADDR == `ASI_ADDR_ACK) begin
         fault_r <= (fault_r & ~WDATA[`ASI_NFAULT-1:0]) | fault_now;
      end else begin
         fault_r <= fault_r | fault_now;
      end
   end
   assign FAULT_ANY = |fault_r;

   // Read data one cycle after the strobe; unmapped reads return zero
   // Zero outside the read slot keeps a stale word from being taken twice
   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         RDATA <= '0;
      end else if (RD) begin
         case (ADDR)
            `ASI_ADDR_CTRL: RDATA <= {26'h0, fr_remote_r, remote_stop_r, manual,
                                      estop_local_r, fr_stop, estop};
            `ASI_ADDR_FAULT: RDATA <= {20'h0, fault_r};
            `ASI_ADDR_STATE: RDATA <= {22'h0, STOW_REQ, BRAKE_SET, REPOINT_REQ,
                                       ENC_BOARD_RESET, backout, lim2, lim1};
            `ASI_ADDR_HEAT: RDATA <= {24'h0, heat_cfg_r};
            `ASI_ADDR_RETRY: RDATA <= {16'h0, retry_cnt_r, retry_max_r};
            `ASI_ADDR_ID: RDATA <= DEVICE_ID;
            default: RDATA <= 32'h0;
         endcase
      end else begin
         RDATA <= 32'h0;
      end
   end
endmodule

// [asi_interlock_checker.sv]
// Port assertions for the antenna safety interlock
`timescale 1ns/1ps
module asi_interlock_checker (
   // Clock, reset and register port
   input wire logic SYS_CLK,
   input wire logic RST,
   input wire logic RD,
   input wire logic [31:0] RDATA,
   // Watched pins
   input wire logic ESTOP_LOCAL,
   input wire logic FR_ESTOP_LOCAL,
   input wire logic MANUAL_MODE,
   input wire logic HZ_OCUR,
   input wire logic HZ_OSPD,
   input wire logic ENC_FAIL,
   input wire logic [1:0] LIMIT2,
   input wire logic WIND_HIGH,
   input wire logic APEX_COLD,
   // Watched outputs
   input wire logic HZ_AXIS_ENABLE,
   input wire logic VT_AXIS_ENABLE,
   input wire logic [1:0] HZ_DRIVE_ON,
   input wire logic [1:0] VT_DRIVE_ON,
   input wire logic THYRISTOR_POWER,
   input wire logic BRAKE_SET,
   input wire logic STOW_REQ,
   input wire logic [1:0] BACKOUT_REQ,
   input wire logic ENC_BOARD_RESET,
   input wire logic FR_POWER,
   input wire logic HEATER_ON,
   input wire logic FAULT_ANY
);
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (RST);
   // Five samples cover the two-flop synchroniser and the state register
   estop_off_a: assert property (ESTOP_LOCAL [*5] |->
      !HZ_AXIS_ENABLE && !VT_AXIS_ENABLE && !THYRISTOR_POWER && BRAKE_SET) else $error("stop ignored");
   fr_cut_a: assert property (FR_ESTOP_LOCAL [*5] |->
      !FR_POWER && !HZ_AXIS_ENABLE && !VT_AXIS_ENABLE) else $error("focus stop ignored");
   limit_cut_a: assert property (LIMIT2[1] [*5] |-> VT_DRIVE_ON == 2'h0)
      else $error("second limit kept drive");
   wind_stow_a: assert property ((WIND_HIGH && !MANUAL_MODE) [*5] |-> STOW_REQ && BRAKE_SET)
      else $error("wind without stow");
   heater_on_a: assert property (APEX_COLD [*5] |-> HEATER_ON)
      else $error("heater off when cold");
   speed_stow_a: assert property ((HZ_OSPD && !MANUAL_MODE) [*5] |-> STOW_REQ)
      else $error("overspeed without stow");
   manual_quiet_a: assert property (MANUAL_MODE [*5] |-> !STOW_REQ && BACKOUT_REQ == 2'h0)
      else $error("automatic action in manual");
   ocur_fault_a: assert property (HZ_OCUR [*5] |-> FAULT_ANY)
      else $error("overcurrent not reported");
   enc_reset_a: assert property ($rose(ENC_FAIL) |-> ##[1:6] ENC_BOARD_RESET)
      else $error("no encoder board reset");
   rd_idle_a: assert property (!$past(RD) |-> RDATA == 32'h0)
      else $error("read data outside slot");
   estop_c: cover property (!HZ_AXIS_ENABLE);
   backout_c: cover property (BACKOUT_REQ[0]);
   stow_c: cover property ($rose(STOW_REQ));
endmodule
bind asi_interlock asi_interlock_checker i_chk (.SYS_CLK, .RST, .RD, .RDATA, .ESTOP_LOCAL,
   .FR_ESTOP_LOCAL, .MANUAL_MODE, .HZ_OCUR, .HZ_OSPD, .ENC_FAIL, .LIMIT2, .WIND_HIGH,
   .APEX_COLD, .HZ_AXIS_ENABLE, .VT_AXIS_ENABLE, .HZ_DRIVE_ON, .VT_DRIVE_ON, .THYRISTOR_POWER,
   .BRAKE_SET, .STOW_REQ, .BACKOUT_REQ, .ENC_BOARD_RESET, .FR_POWER, .HEATER_ON, .FAULT_ANY);

// [asi_drive_model.sv]
// Drive-side model: first limit switch that clears once the axis backs out
`timescale 1ns/1ps
module asi_drive_model #(
   parameter int BACK_CYCLES = 6
) (
   // Clock and reset
   input wire logic SYS_CLK,
   input wire logic RST,
   // Bench pushes an axis into its first limit
   input wire logic [1:0] overrun,
   // Interlock side
   input wire logic [1:0] backout_req,
   output logic [1:0] limit1
);
   int cnt_r [2];
   // Switch stays made until the axis has moved back long enough
   always_ff @(posedge SYS_CLK) begin
      for (int i = 0; i < 2; i++) begin
         if (RST) begin
            limit1[i] <= 1'b0;
            cnt_r[i] <= 0;
         end else if (overrun[i]) begin
            limit1[i] <= 1'b1;
            cnt_r[i] <= 0;
         end else if (limit1[i] && backout_req[i]) begin
            cnt_r[i] <= cnt_r[i] + 1;
            if (cnt_r[i] == BACK_CYCLES - 1) limit1[i] <= 1'b0;
         end
      end
   end
endmodule

// [tb_top.sv]
// Self-checking bench for the antenna safety interlock
`timescale 1ns/1ps
`include "asi_params.svh"
`define CHK(x, y) begin cmp_count++; if ((x) !== (y)) begin miscompares++; \
$display("[FAIL] %0t got %0h expected %0h", $time, (x), (y)); end end
`define WAITC(c) repeat (40) if (!(c)) cyc(1);
module tb_top;
   logic SYS_CLK, RST, WR, RD, ESTOP_LOCAL, FR_ESTOP_LOCAL, MANUAL_MODE, OTHER_BRK_OPEN, HZ_OCUR;
   logic VT_OCUR, HZ_OSPD, VT_OSPD, ENC_FAIL, VT_OK, WIND_HIGH, APEX_COLD, APEX_MOVE_FAIL;
   logic [3:0] ADDR;
   logic [31:0] WDATA, RDATA, rd_v;
   logic [1:0] HZ_OTEMP, VT_OTEMP, HZ_BRK_OPEN, VT_BRK_OPEN, LIMIT1, LIMIT2, overrun;
   logic HZ_AXIS_ENABLE, VT_AXIS_ENABLE, THYRISTOR_POWER, BRAKE_SET, STOW_REQ, ENC_BOARD_RESET;
   logic REPOINT_REQ, FR_POWER, TRANSLATOR_ENABLE, HEATER_ON, FAULT_ANY;
   logic [1:0] HZ_DRIVE_ON, VT_DRIVE_ON, BACKOUT_REQ;
   int miscompares = 0;
   int cmp_count = 0;
   // Short contact-loss window and encoder reset pulse keep the run brief
   asi_interlock #(.COMM_CYCLES(300), .ENC_RST_CYCLES(4)) i_dut (.SYS_CLK, .RST, .ADDR, .WDATA,
      .WR, .RD, .RDATA, .ESTOP_LOCAL, .FR_ESTOP_LOCAL, .MANUAL_MODE, .HZ_OTEMP, .VT_OTEMP,
      .HZ_BRK_OPEN, .VT_BRK_OPEN, .OTHER_BRK_OPEN, .HZ_OCUR, .VT_OCUR, .HZ_OSPD, .VT_OSPD,
      .ENC_FAIL, .VT_OK, .LIMIT1, .LIMIT2, .WIND_HIGH, .APEX_COLD, .APEX_MOVE_FAIL,
      .HZ_AXIS_ENABLE, .VT_AXIS_ENABLE, .HZ_DRIVE_ON, .VT_DRIVE_ON, .THYRISTOR_POWER,
      .BRAKE_SET, .STOW_REQ, .BACKOUT_REQ, .ENC_BOARD_RESET, .REPOINT_REQ, .FR_POWER,
      .TRANSLATOR_ENABLE, .HEATER_ON, .FAULT_ANY);
   asi_drive_model #(.BACK_CYCLES(6)) i_model (.SYS_CLK, .RST, .overrun,
      .backout_req(BACKOUT_REQ), .limit1(LIMIT1));
   task automatic cyc(input int n);
      repeat (n) @(posedge SYS_CLK);
      #1;
   endtask
   function automatic logic [31:0] bit_of(input int b);
      return 32'h1 << b;
   endfunction
   // Bus cycles: one strobe cycle each, read data taken in the following cycle
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge SYS_CLK);
      ADDR <= a;
      WDATA <= d;
      WR <= 1'b1;
      @(posedge SYS_CLK);
      WR <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [3:0] a);
      @(posedge SYS_CLK);
      ADDR <= a;
      RD <= 1'b1;
      @(posedge SYS_CLK);
      RD <= 1'b0;
      #1;
      rd_v = RDATA;
   endtask
   // Release stops, keep contact alive and acknowledge every fault
   task automatic clear_all;
      wr(`ASI_ADDR_CTRL, bit_of(`ASI_CTRL_ESTOP_CLR) | bit_of(`ASI_CTRL_FR_CLR) |
         bit_of(`ASI_CTRL_KEEPALIVE));
      wr(`ASI_ADDR_ACK, 32'hFFFFFFFF);
      cyc(3);
   endtask
   task automatic t_regs;
      rd(`ASI_ADDR_RETRY);
      `CHK(rd_v[7:0], `ASI_RETRY_RESET)
      rd(`ASI_ADDR_HEAT);
      `CHK(rd_v[7:0], `ASI_HEAT_RESET)
      rd(4'hF);
      `CHK(rd_v, 32'h0)
      rd(`ASI_ADDR_FAULT);
      `CHK(rd_v[11:0], 12'h000)
      `CHK({HZ_AXIS_ENABLE, FR_POWER, TRANSLATOR_ENABLE, HEATER_ON}, 4'hE)
      wr(`ASI_ADDR_HEAT, 32'h1);
      rd(`ASI_ADDR_HEAT);
      `CHK({HEATER_ON, rd_v[7:0]}, 9'h101)
      wr(`ASI_ADDR_HEAT, 32'h0);
      rd(`ASI_ADDR_ID);
      `CHK(rd_v, `ASI_DEVICE_ID)
   endtask
   // Local stop survives a remote clear; remote stop leaves focus running
   task automatic t_estop;
      @(posedge SYS_CLK);
      ESTOP_LOCAL <= 1'b1;
      cyc(6);
      `CHK({HZ_AXIS_ENABLE, VT_AXIS_ENABLE, THYRISTOR_POWER, BRAKE_SET, FR_POWER}, 5'h03)
      wr(`ASI_ADDR_CTRL, bit_of(`ASI_CTRL_ESTOP_CLR));
      cyc(3);
      `CHK(HZ_AXIS_ENABLE, 1'b0)
      @(posedge SYS_CLK);
      ESTOP_LOCAL <= 1'b0;
      cyc(4);
      rd(`ASI_ADDR_FAULT);
      `CHK(rd_v[`ASI_F_ESTOP], 1'b1)
      clear_all;
      rd(`ASI_ADDR_FAULT);
      `CHK({HZ_AXIS_ENABLE, rd_v[11:0]}, 13'h1000)
      wr(`ASI_ADDR_CTRL, bit_of(`ASI_CTRL_ESTOP_SET));
      cyc(3);
      `CHK({VT_AXIS_ENABLE, FR_POWER}, 2'b01)
      clear_all;
      `CHK(VT_AXIS_ENABLE, 1'b1)
   endtask
   task automatic t_fr;
      @(posedge SYS_CLK);
      FR_ESTOP_LOCAL <= 1'b1;
      cyc(6);
      `CHK({FR_POWER, HZ_AXIS_ENABLE, THYRISTOR_POWER}, 3'h0)
      @(posedge SYS_CLK);
      FR_ESTOP_LOCAL <= 1'b0;
      cyc(4);
      clear_all;
      wr(`ASI_ADDR_CTRL, bit_of(`ASI_CTRL_FR_SET));
      cyc(3);
      `CHK({FR_POWER, VT_AXIS_ENABLE}, 2'b00)
      clear_all;
      `CHK({FR_POWER, VT_AXIS_ENABLE}, 2'b11)
   endtask
   // Manual mode hides wind and remote commands; wind stow then holds until calm
   task automatic t_manual;
      clear_all;
      @(posedge SYS_CLK);
      MANUAL_MODE <= 1'b1;
      WIND_HIGH <= 1'b1;
      cyc(6);
      wr(`ASI_ADDR_CTRL, bit_of(`ASI_CTRL_ESTOP_SET));
      cyc(3);
      `CHK({HZ_AXIS_ENABLE, STOW_REQ}, 2'b10)
      @(posedge SYS_CLK);
      MANUAL_MODE <= 1'b0;
      cyc(6);
      `CHK({STOW_REQ, BRAKE_SET}, 2'b11)
      @(posedge SYS_CLK);
      WIND_HIGH <= 1'b0;
      cyc(5);
      `CHK({STOW_REQ, BRAKE_SET}, 2'b00)
      clear_all;
   endtask
   task automatic t_limits;
      clear_all;
      @(posedge SYS_CLK);
      overrun <= 2'b01;
      @(posedge SYS_CLK);
      overrun <= 2'b00;
      `WAITC(BACKOUT_REQ[0])
      `CHK(BACKOUT_REQ, 2'b01)
      `WAITC(REPOINT_REQ)
      `CHK({REPOINT_REQ, BACKOUT_REQ}, 3'b100)
      cyc(1);
      `CHK({ENC_BOARD_RESET, LIMIT1[0]}, 2'b10)
      @(posedge SYS_CLK);
      LIMIT2 <= 2'b10;
      cyc(6);
      `CHK({VT_DRIVE_ON, HZ_DRIVE_ON}, 4'h3)
      @(posedge SYS_CLK);
      LIMIT2 <= 2'b00;
      cyc(4);
      clear_all;
   endtask
   // Each try is a four-cycle failure report followed by four quiet cycles
   task automatic apex_tries(input int n);
      repeat (n) begin
         @(posedge SYS_CLK);
         APEX_MOVE_FAIL <= 1'b1;
         cyc(3);
         @(posedge SYS_CLK);
         APEX_MOVE_FAIL <= 1'b0;
         cyc(3);
      end
   endtask
   // Sensor faults, one motor first so stow must stay off
   task automatic t_faults;
      @(posedge SYS_CLK);
      HZ_OTEMP <= 2'b01;
      VT_BRK_OPEN <= 2'b10;
      cyc(6);
      `CHK({HZ_DRIVE_ON, VT_DRIVE_ON, STOW_REQ}, 5'b10010)
      @(posedge SYS_CLK);
      {HZ_OTEMP, VT_BRK_OPEN} <= 4'h0;
      {HZ_OSPD, HZ_OCUR, APEX_COLD} <= 3'h7;
      cyc(6);
      `CHK({STOW_REQ, FAULT_ANY, HEATER_ON}, 3'h7)
      rd(`ASI_ADDR_FAULT);
      `CHK(rd_v[`ASI_F_OCUR], 1'b1)
      @(posedge SYS_CLK);
      {HZ_OSPD, HZ_OCUR, APEX_COLD} <= 3'h0;
      {OTHER_BRK_OPEN, ENC_FAIL} <= 2'h3;
      `WAITC(ENC_BOARD_RESET)
      `CHK(ENC_BOARD_RESET, 1'b1)
      cyc(20);
      rd(`ASI_ADDR_FAULT);
      `CHK({STOW_REQ, rd_v[`ASI_F_ENC], rd_v[`ASI_F_BRK], HZ_DRIVE_ON}, 5'h1F)
      cyc(120);
      `CHK({HZ_DRIVE_ON, VT_DRIVE_ON}, 4'h0)
      @(posedge SYS_CLK);
      {OTHER_BRK_OPEN, ENC_FAIL} <= 2'h0;
      `CHK(TRANSLATOR_ENABLE, 1'b1)
      apex_tries(3);
      `CHK(TRANSLATOR_ENABLE, 1'b1)
      apex_tries(2);
      `CHK(TRANSLATOR_ENABLE, 1'b0)
      wr(`ASI_ADDR_CTRL, bit_of(`ASI_CTRL_STOW_DONE));
      `CHK(TRANSLATOR_ENABLE, 1'b1)
   endtask
   task automatic t_comm;
      clear_all;
      cyc(250);
      rd(`ASI_ADDR_FAULT);
      `CHK(rd_v[`ASI_F_COMM], 1'b0)
      cyc(80);
      rd(`ASI_ADDR_FAULT);
      `CHK({STOW_REQ, rd_v[`ASI_F_COMM]}, 2'b11)
   endtask
   task automatic end_sim;
      if (miscompares == 0 && cmp_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   initial begin
      SYS_CLK = 1'b0;
      forever #10 SYS_CLK = ~SYS_CLK;
   end
   // Hang guard, well beyond the expected run
   initial begin
      repeat (20000) @(posedge SYS_CLK);
      miscompares++;
      end_sim;
   end
   initial begin
      {WR, RD, ESTOP_LOCAL, FR_ESTOP_LOCAL, MANUAL_MODE, OTHER_BRK_OPEN, HZ_OCUR} = 7'h00;
      {VT_OCUR, HZ_OSPD, VT_OSPD, ENC_FAIL, WIND_HIGH, APEX_COLD, APEX_MOVE_FAIL} = 7'h00;
      {HZ_OTEMP, VT_OTEMP, HZ_BRK_OPEN, VT_BRK_OPEN, LIMIT2, overrun} = 12'h000;
      ADDR = 4'h0;
      WDATA = 32'h0;
      VT_OK = 1'b1;
      RST = 1'b1;
      repeat (12) @(posedge SYS_CLK);
      RST <= 1'b0;
      cyc(1);
      t_regs;
      t_estop;
      t_fr;
      t_manual;
      t_limits;
      t_faults;
      t_comm;
      end_sim;
   end
endmodule
